// ### hw/dma_ctrl_b_map.vh
`ifndef DMA_CTRL_B_MAP_VH
`define DMA_CTRL_B_MAP_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_CTRL_B        4'h0
`define ADDR_CTRL_A        4'h4
`define ADDR_DST_ADDR      4'h8
`define ADDR_COUNT         4'hC
// ----------------------------------------
// channel_control_b fields
// ----------------------------------------
`define CB_MASTER_EN       7
`define CB_SPARE           6
`define CB_DST_DIR         5
`define CB_DST_STEP        4
`define CB_BLOCK_SRC       3
`define CB_ACT_HI          2
`define CB_ACT_LO          0
`define CB_RESET           8'h00
// ----------------------------------------
// channel_control_a fields
// ----------------------------------------
`define CA_CHAN_EN         7
`define CA_SIZE            6
`define CA_FULL_HI         2
`define CA_FULL_LO         1
`define CA_BLOCK_MODE      0
`define CA_RESET           8'h00
// ----------------------------------------
// activation codes
// ----------------------------------------
`define ACT_BURST          3'h0
`define ACT_STEAL          3'h2
`define ACT_FALL           3'h6
`define ACT_LOW            3'h7
`define ACT_TMR_LAST       3'h3
// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// ### hw/req_sync.v
// ----------------------------------------
// request pin synchroniser and detector
// ----------------------------------------
module req_sync (
  // clock and reset
  input  wire ref_clk,
  input  wire rst_n,
  // pin and results
  input  wire ext_xfer_request_n,
  output reg  req_low,
  output wire req_fall
);
  reg meta;
  reg prev;

  // two stages before any logic reads the pin
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta    <= 1'b1;
      req_low <= 1'b0;
      prev    <= 1'b1;
    end else begin
      meta    <= ext_xfer_request_n;
      req_low <= ~meta;
      prev    <= ~req_low;
    end
  end

  // one pulse per high-to-low transition
  assign req_fall = prev & req_low;
endmodule

// ### hw/dma_full_address_ctrl_b.v
// Behaviour
// - control b clears on reset and standby
// - transfer needs master and channel enable
// - nmi clears master enable
// - suspended transfer resumes from same point
// - master enable set only after read
// - bit six stores and returns value
// - step disabled holds destination fixed
// - step up by one or two
// - step down by one or two
// - bit three picks block area side
// - normal mode activation codes four legal
// - low level code requests while pin low
// - block mode timer or falling edge
// - falling edge gives one request
// - shared event served in priority order
// - full address needs both select bits
// - size bit picks byte or word
// - steal releases bus; burst holds it
// - channel enable clears at count end
`include "dma_ctrl_b_map.vh"
module dma_full_address_ctrl_b #(
  parameter AW = 24
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          rst_n,
  // system events
  input  wire          standby,
  input  wire          nmi_pulse,
  input  wire [3:0]    timer_match_a,
  input  wire          higher_chan_busy,
  input  wire          higher_master_req,
  // external request pin
  input  wire          ext_xfer_request_n,
  // transfer engine handshake
  output wire          xfer_req,
  input  wire          xfer_done,
  output reg           bus_hold,
  output wire          xfer_word,
  output wire          block_src_side,
  output reg  [AW-1:0] dst_address_reg,
  // axi4-lite write address
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [3:0]    s_axi_awaddr,
  // axi4-lite write data
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  // axi4-lite write response
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  output reg  [1:0]    s_axi_bresp,
  // axi4-lite read address
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  input  wire [3:0]    s_axi_araddr,
  // axi4-lite read data
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0]  channel_control_b;
  reg  [7:0]  channel_control_a;
  reg  [15:0] xfer_count;
  reg         read_armed_b;
  reg         read_armed_a;
  reg         aw_held;
  reg  [3:0]  aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         pend_req;
  wire        req_low;
  wire        req_fall;

  function is_legal;
    input [2:0] code;
    input       blk;
    begin
      if (blk)
        is_legal = (code <= `ACT_TMR_LAST) || (code == `ACT_FALL);
      else
        is_legal = (code == `ACT_BURST) || (code == `ACT_STEAL) ||
                   (code == `ACT_FALL) || (code == `ACT_LOW);
    end
  endfunction

  req_sync u_req_sync (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .ext_xfer_request_n (ext_xfer_request_n),
    .req_low            (req_low),
    .req_fall           (req_fall)
  );

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  wire [2:0] act     = channel_control_b[`CB_ACT_HI:`CB_ACT_LO];
  wire       blk     = channel_control_a[`CA_BLOCK_MODE];
  wire       full    = channel_control_a[`CA_FULL_HI] &
                       channel_control_a[`CA_FULL_LO];
  wire       enabled = full & channel_control_b[`CB_MASTER_EN] &
                       channel_control_a[`CA_CHAN_EN];
  wire       legal   = is_legal(act, blk);

  assign xfer_word      = channel_control_a[`CA_SIZE];
  assign block_src_side = channel_control_b[`CB_BLOCK_SRC];

  // ----------------------------------------
  // request selection
  // ----------------------------------------
  reg trig;
  always @* begin
    trig = 1'b0;
    if (blk) begin
      if (act <= `ACT_TMR_LAST)
        trig = timer_match_a[act[1:0]];
      else if (act == `ACT_FALL)
        trig = req_fall;
    end else begin
      case (act)
        `ACT_BURST: trig = 1'b1;
        `ACT_STEAL: trig = 1'b1;
        `ACT_FALL:  trig = req_fall;
        `ACT_LOW:   trig = req_low;
        default:    trig = 1'b0;
      endcase
    end
  end

  wire level_src = ~blk & (act != `ACT_FALL) &
                   ((act == `ACT_LOW) | (act == `ACT_BURST) | (act == `ACT_STEAL));
  // pending edge/timer events survive a suspend; a higher channel on the same event
  // goes first, so this one waits while it is busy
  wire want = level_src ? trig : pend_req;
  assign xfer_req = enabled & legal & want & ~higher_chan_busy;

  // ----------------------------------------
  // bus hold for auto-request
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      bus_hold <= 1'b0;
    else if (standby)
      bus_hold <= 1'b0;
    else
      bus_hold <= enabled & ~blk & (act == `ACT_BURST) & ~higher_master_req;
  end

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  wire aw_ok  = aw_held | s_axi_awvalid;
  wire w_ok   = w_held  | s_axi_wvalid;
  wire wr_go  = aw_ok & w_ok & ~s_axi_bvalid;
  wire [3:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held  ? w_data  : s_axi_wdata;
  wire        wb = w_held  ? w_strb[0] : s_axi_wstrb[0];
  wire rd_go  = s_axi_arvalid & ~s_axi_rvalid;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held  & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire wr_b   = wr_go & wb & (wa == `ADDR_CTRL_B);
  wire wr_a   = wr_go & wb & (wa == `ADDR_CTRL_A);
  wire wr_d   = wr_go & (wa == `ADDR_DST_ADDR);
  wire wr_c   = wr_go & (wa == `ADDR_COUNT);
  wire rd_b   = rd_go & (s_axi_araddr == `ADDR_CTRL_B);
  wire rd_a   = rd_go & (s_axi_araddr == `ADDR_CTRL_A);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wa == `ADDR_CTRL_B || wa == `ADDR_CTRL_A || wa == `ADDR_DST_ADDR ||
                         wa == `ADDR_COUNT) ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_CTRL_B:   s_axi_rdata <= {24'h000000, channel_control_b};
          `ADDR_CTRL_A:   s_axi_rdata <= {24'h000000, channel_control_a};
          `ADDR_DST_ADDR: s_axi_rdata <= {{(32-AW){1'b0}}, dst_address_reg};
          `ADDR_COUNT:    s_axi_rdata <= {16'h0000, xfer_count};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control b
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_control_b <= `CB_RESET;
      read_armed_b      <= 1'b0;
    end else if (standby) begin
      channel_control_b <= `CB_RESET;
      read_armed_b      <= 1'b0;
    end else begin
      if (rd_b & ~channel_control_b[`CB_MASTER_EN])
        read_armed_b <= 1'b1;
      else if (wr_b)
        read_armed_b <= 1'b0;
      if (wr_b) begin
        channel_control_b[6:0] <= wd[6:0];
        if (!wd[`CB_MASTER_EN])
          channel_control_b[`CB_MASTER_EN] <= 1'b0;
        else if (read_armed_b)
          channel_control_b[`CB_MASTER_EN] <= 1'b1;
      end
      // nmi wins over a same-cycle set so the cpu gets the bus
      if (nmi_pulse)
        channel_control_b[`CB_MASTER_EN] <= 1'b0;
    end
  end

  // ----------------------------------------
  // control a, count, destination
  // ----------------------------------------
  wire last = xfer_done & enabled & (xfer_count == 16'h0001);
  wire [AW-1:0] step = xfer_word ? {{(AW-2){1'b0}}, 2'b10} : {{(AW-1){1'b0}}, 1'b1};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_control_a <= `CA_RESET;
      read_armed_a      <= 1'b0;
      xfer_count        <= 16'h0000;
      dst_address_reg   <= {AW{1'b0}};
      pend_req          <= 1'b0;
    end else if (standby) begin
      channel_control_a <= `CA_RESET;
      read_armed_a      <= 1'b0;
      pend_req          <= 1'b0;
    end else begin
      if (rd_a & ~channel_control_a[`CA_CHAN_EN])
        read_armed_a <= 1'b1;
      else if (wr_a)
        read_armed_a <= 1'b0;
      if (wr_a) begin
        channel_control_a[6:0] <= wd[6:0];
        if (!wd[`CA_CHAN_EN])
          channel_control_a[`CA_CHAN_EN] <= 1'b0;
        else if (read_armed_a)
          channel_control_a[`CA_CHAN_EN] <= 1'b1;
      end
      if (last)
        channel_control_a[`CA_CHAN_EN] <= 1'b0;
      if (wr_c)
        xfer_count <= wd[15:0];
      else if (xfer_done & enabled)
        xfer_count <= xfer_count - 16'h0001;
      if (wr_d)
        dst_address_reg <= wd[AW-1:0];
      else if (xfer_done & enabled & channel_control_b[`CB_DST_STEP]) begin
        if (channel_control_b[`CB_DST_DIR])
          dst_address_reg <= dst_address_reg - step;
        else
          dst_address_reg <= dst_address_reg + step;
      end
      // edge and timer events are kept while suspended
      if (trig & ~level_src & channel_control_a[`CA_CHAN_EN])
        pend_req <= 1'b1;
      else if (xfer_done & enabled)
        pend_req <= 1'b0;
    end
  end
endmodule

// ### tb/req_pin_model.sv
module req_pin_model (
  // clock and command
  input  wire logic ref_clk,
  input  wire logic pin_low,
  // request pin, idles high
  output logic      ext_xfer_request_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // moves on the falling edge, so the device must synchronise it
  always @(negedge ref_clk) ext_xfer_request_n <= !pin_low;
endmodule

// ### tb/dma_ctrl_b_chk.sv
module dma_ctrl_b_chk #(
  parameter int AW = 24
) (
  // clock and reset
  input wire logic          ref_clk,
  input wire logic          rst_n,
  // events and handshake
  input wire logic          standby,
  input wire logic          nmi_pulse,
  input wire logic          higher_chan_busy,
  input wire logic          higher_master_req,
  input wire logic          xfer_req,
  input wire logic          xfer_done,
  input wire logic          bus_hold,
  input wire logic          xfer_word,
  input wire logic [AW-1:0] dst_address_reg,
  // register bus
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_stby;
    standby |=> !xfer_req;
  endproperty
  a_stby: assert property (p_stby) else $error("request after standby");
  property p_nmi;
    nmi_pulse |=> !xfer_req;
  endproperty
  a_nmi: assert property (p_nmi) else $error("request after nmi");
  property p_busy;
    higher_chan_busy |-> !xfer_req;
  endproperty
  a_busy: assert property (p_busy) else $error("request while higher busy");
  property p_dchg;
    $changed(dst_address_reg) |-> $past(xfer_done) || $rose(s_axi_bvalid);
  endproperty
  a_dchg: assert property (p_dchg) else $error("destination moved alone");
  property p_step;
    $past(xfer_done) && $changed(dst_address_reg) |->
      dst_address_reg == $past(dst_address_reg) + ($past(xfer_word) ? 2 : 1) ||
      dst_address_reg == $past(dst_address_reg) - ($past(xfer_word) ? 2 : 1);
  endproperty
  a_step: assert property (p_step) else $error("wrong step size");
  property p_bus;
    higher_master_req |-> ##[0:1] !bus_hold;
  endproperty
  a_bus: assert property (p_bus) else $error("bus kept from master");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  property p_rref;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rref: assert property (p_rref) else $error("read taken while busy");
endmodule

bind dma_full_address_ctrl_b dma_ctrl_b_chk #(.AW(AW)) chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .standby(standby), .nmi_pulse(nmi_pulse),
  .higher_chan_busy(higher_chan_busy), .higher_master_req(higher_master_req),
  .xfer_req(xfer_req), .xfer_done(xfer_done), .bus_hold(bus_hold), .xfer_word(xfer_word),
  .dst_address_reg(dst_address_reg), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ### tb/tb_dma_full_address_ctrl_b.sv
module tb_dma_full_address_ctrl_b;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        standby = 1'b0;
  logic        nmi = 1'b0;
  logic [3:0]  tmr = 4'h0;
  logic        busy = 1'b0;
  logic        hreq = 1'b0;
  logic        done = 1'b0;
  logic        pin_low = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, brd = 1'b0, rrd = 1'b0;
  logic [3:0]  awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [1:0]  bsp = 2'h0, rsp = 2'h0;
  wire  [31:0] rdat;
  wire  [23:0] dst;
  wire  [1:0]  bresp, rresp;
  wire         ext_n, xreq, hold, word, bsrc, awr, wr_r, bv, arr, rv;
  int          error_cnt = 0;
  int          checked = 0;
  dma_full_address_ctrl_b #(.AW(24)) dma_full_address_ctrl_b_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .standby(standby), .nmi_pulse(nmi),
    .timer_match_a(tmr), .higher_chan_busy(busy), .higher_master_req(hreq),
    .ext_xfer_request_n(ext_n), .xfer_req(xreq), .xfer_done(done), .bus_hold(hold),
    .xfer_word(word), .block_src_side(bsrc), .dst_address_reg(dst),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rrd), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp));
  req_pin_model req_pin_model_i (.ref_clk(ref_clk), .pin_low(pin_low), .ext_xfer_request_n(ext_n));
  always #20 ref_clk = ~ref_clk;
  // ----------------------------------------
  // bus and handshake tasks
  // ----------------------------------------
  task results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task tmo(inout int n);
    n++;
    if (n > 100) begin
      error_cnt++;
      $display("ERROR %0t wait timed out", $time);
      results;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    brd <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
      tmo(n);
    end while ((awv && !awr) || (wv && !wr_r) || !bv);
    bsp = bresp;
    brd <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    arv <= 1'b1;
    ara <= a;
    rrd <= 1'b1;
    do begin @(posedge ref_clk); tmo(n); end while (!arr);
    arv <= 1'b0;
    do begin @(posedge ref_clk); tmo(n); end while (!rv);
    d = rdat;
    rsp = rresp;
    rrd <= 1'b0;
  endtask
  task arm(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] t;
    rd(a, t);
    wr(a, d);
  endtask
  task setup(input logic [31:0] ca, cb, da, cnt);
    @(posedge ref_clk) standby <= 1'b1;
    @(posedge ref_clk) standby <= 1'b0;
    wr(4'h8, da);
    wr(4'hC, cnt);
    arm(4'h4, ca);
    arm(4'h0, cb);
  endtask
  task xfer(input int k);
    int n;
    n = 0;
    repeat (k) begin
      do begin @(posedge ref_clk); tmo(n); end while (!xreq);
      done <= 1'b1;
      @(posedge ref_clk) done <= 1'b0;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task s_regs;
    logic [31:0] d;
    rd(4'h0, d);
    `CHK(d, 32'h0)
    `CHK(rsp, 2'h0)
    wr(4'h0, 32'h40);
    `CHK(bsp, 2'h0)
    wr(4'h0, 32'hFF);
    rd(4'h0, d);
    `CHK(d, 32'h7F)
    @(posedge ref_clk) standby <= 1'b1;
    @(posedge ref_clk) standby <= 1'b0;
    rd(4'h0, d);
    `CHK(d, 32'h0)
    // unmapped word answers with an error and reads zero
    wr(4'h2, 32'h1);
    `CHK(bsp, 2'h2)
    rd(4'h2, d);
    `CHK(rsp, 2'h2)
    `CHK(d, 32'h0)
  endtask
  task s_rst;
    logic [31:0] d;
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(1);
    `CHK(xreq, 1'b0)
    `CHK(hold, 1'b0)
    rd(4'h0, d);
    `CHK(d, 32'h0)
  endtask
  task s_step;
    logic [23:0] e;
    for (int i = 0; i < 5; i++) begin
      // pass two runs cycle-steal, the rest burst
      setup({1'b1, i[1], 6'h06}, {2'b10, i[0], i < 4, 2'b00, i == 2, 1'b0}, 32'h100, 32'h2);
      cyc(2);
      `CHK(xreq, 1'b1)
      `CHK(word, i[1])
      `CHK(hold, i != 2)
      @(posedge ref_clk) hreq <= 1'b1;
      cyc(2);
      `CHK(hold, 1'b0)
      @(posedge ref_clk) hreq <= 1'b0;
      xfer(2);
      cyc(2);
      `CHK(xreq, 1'b0)
      e = i > 3 ? 24'h100 : i[0] ? 24'h100 - (i[1] ? 4 : 2) : 24'h100 + (i[1] ? 4 : 2);
      `CHK(dst, e)
    end
  endtask
  task s_nmi;
    logic [31:0] d;
    setup(32'h86, 32'h90, 32'h100, 32'h3);
    xfer(1);
    @(posedge ref_clk) nmi <= 1'b1;
    @(posedge ref_clk) nmi <= 1'b0;
    cyc(2);
    `CHK(xreq, 1'b0)
    rd(4'h0, d);
    `CHK(d[7], 1'b0)
    wr(4'h0, 32'h90);
    xfer(2);
    cyc(2);
    `CHK(dst, 24'h103)
  endtask
  task s_pin;
    setup(32'h86, 32'h91, 32'h100, 32'h8);
    cyc(3);
    `CHK(xreq, 1'b0)
    wr(4'h0, 32'h07);
    arm(4'h0, 32'h97);
    cyc(3);
    `CHK(xreq, 1'b0)
    @(posedge ref_clk) pin_low <= 1'b1;
    cyc(6);
    `CHK(xreq, 1'b1)
    xfer(1);
    @(posedge ref_clk) pin_low <= 1'b0;
    cyc(6);
    `CHK(xreq, 1'b0)
    wr(4'h0, 32'h06);
    arm(4'h0, 32'h96);
    @(posedge ref_clk) pin_low <= 1'b1;
    cyc(6);
    `CHK(xreq, 1'b1)
    xfer(1);
    cyc(6);
    `CHK(xreq, 1'b0)
    @(posedge ref_clk) pin_low <= 1'b0;
  endtask
  task s_block;
    for (int i = 0; i < 4; i++) begin
      setup(32'h87, 32'h88 | i, 32'h100, 32'h8);
      cyc(2);
      `CHK(bsrc, 1'b1)
      @(posedge ref_clk) tmr <= 4'h1 << ((i + 1) % 4);
      @(posedge ref_clk) tmr <= 4'h0;
      cyc(3);
      `CHK(xreq, 1'b0)
      @(posedge ref_clk) tmr <= 4'h1 << i;
      @(posedge ref_clk) tmr <= 4'h0;
      @(posedge ref_clk) busy <= 1'b1;
      cyc(2);
      `CHK(xreq, 1'b0)
      @(posedge ref_clk) busy <= 1'b0;
      cyc(2);
      `CHK(xreq, 1'b1)
      xfer(1);
    end
    // block mode, pin edge source
    setup(32'h87, 32'h8E, 32'h100, 32'h8);
    cyc(3);
    `CHK(xreq, 1'b0)
    @(posedge ref_clk) pin_low <= 1'b1;
    cyc(6);
    `CHK(xreq, 1'b1)
    xfer(1);
    cyc(2);
    `CHK(xreq, 1'b0)
    @(posedge ref_clk) pin_low <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_regs;
    s_step;
    s_nmi;
    s_pin;
    s_block;
    s_rst;
    results;
  end
endmodule
